// ===== rtl/flash_seq_regs.vh
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH

// Command bytes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_PAGE_WRITE 8'h02
`define OP_SMALL_ERASE 8'h20
`define OP_LARGE_ERASE 8'hD8
`define OP_FULL_ERASE 8'hC7
`define OP_SLEEP 8'hB9
`define OP_WAKE 8'hAB

// Status byte field positions
`define STAT_BUSY_BIT 0
`define STAT_LATCH_BIT 1
`define STAT_PROT_LSB 2

// Byte counts of each frame
`define ADDR_LAST_BYTE 10'h004
`define ID_FIRST_BYTE 10'h004
`define SINGLE_BYTE 10'h001

// Array geometry masks
`define PAGE_MASK 24'h0000FF
`define SMALL_MASK 24'h000FFF
`define LARGE_MASK 24'h00FFFF

// Array operation codes
`define MEMOP_PROG 2'h0
`define MEMOP_SMALL 2'h1
`define MEMOP_LARGE 2'h2
`define MEMOP_FULL 2'h3

// Reset values
`define RST_LATCH 1'h0
`define RST_SLEEP 1'h0
`define RST_SO 1'h0

// Timing, in microseconds, and clock rate
`define CLK_MHZ 32'h00000064
`define PAGE_WRITE_TIME_US 32'h000003E8
`define SMALL_ERASE_TIME_US 32'h00002710
`define LARGE_ERASE_TIME_US 32'h000186A0
`define FULL_ERASE_TIME_US 32'h000F4240
`define SLEEP_ENTRY_TIME_US 32'h00000003
`define WAKE_TIME_US 32'h00000003
`define WAKE_WITH_ID_TIME_US 32'h00000002

`endif

// ===== rtl/flash_seq.v
// Contract
// - 02h, 24-bit address, data, select held low
// - Write/erase refused unless latch set
// - Page offset wraps within 256 bytes
// - Only addressed bytes programmed, ones toward data
// - Select rise off byte boundary discards command
// - Page write self-timed, busy, then latch clears
// - Status read answered while busy
// - Protected targets not written or erased
// - 20h plus address erases 4K sector
// - Sector erase self-timed, busy, latch clears
// - D8h plus address erases 64K block
// - Block erase self-timed, busy, latch clears
// - C7h alone, select after eighth bit
// - Chip erase self-timed, busy, latch clears
// - Chip erase refused if anything protected
// - B9h enters sleep within entry time
// - Asleep, only wake command is recognised
// - Comes up awake after power-up
// - ABh alone wakes after wake time
// - ABh plus three dummies streams ID
// - ID readout wakes after shorter wake time
// - Wake or ID ignored while busy
// - 06h sets latch for one operation
// - Input bits taken on rising clock
// - Every byte most significant bit first
`timescale 1ns/1ps
`include "flash_seq_regs.vh"

module page_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // Drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] cnt_ff;
    wire push;
    wire pop;

    assign in_ready_out = (cnt_ff != DEPTH[AW:0]);
    assign out_valid_out = (cnt_ff != {(AW+1){1'b0}});
    assign out_data_out = mem_ff[rd_ptr_ff];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            if (push & !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop & !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // page_fifo

module flash_seq #(
    parameter [31:0] PAGE_WRITE_CYC = `PAGE_WRITE_TIME_US * `CLK_MHZ,
    parameter [31:0] SMALL_ERASE_CYC = `SMALL_ERASE_TIME_US * `CLK_MHZ,
    parameter [31:0] LARGE_ERASE_CYC = `LARGE_ERASE_TIME_US * `CLK_MHZ,
    parameter [31:0] FULL_ERASE_CYC = `FULL_ERASE_TIME_US * `CLK_MHZ,
    parameter [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Serial link
    input wire cs_n_in,
    input wire sclk_in,
    input wire serial_in_io_in,
    output wire serial_in_io_out,
    output wire serial_in_io_oe_out,
    output wire so_out,
    output wire so_oe_out,
    // Protection
    input wire protect_sel_3_in,
    input wire protect_sel_2_in,
    input wire protect_sel_1_in,
    input wire protect_sel_0_in,
    input wire prot_valid_in,
    input wire [23:0] prot_lo_in,
    input wire [23:0] prot_hi_in,
    // Array operation port
    output wire mem_valid_out,
    input wire mem_ready_in,
    output wire [1:0] mem_op_out,
    output wire [23:0] mem_addr_out,
    output wire [7:0] mem_data_out,
    // Status
    output wire busy_out,
    output wire write_latch_flag_out,
    output wire sleep_out
);
    localparam [31:0] SLEEP_CYC_W = `SLEEP_ENTRY_TIME_US * `CLK_MHZ;
    localparam [31:0] WAKE_CYC_W = `WAKE_TIME_US * `CLK_MHZ;
    localparam [31:0] WAKE_ID_CYC_W = `WAKE_WITH_ID_TIME_US * `CLK_MHZ;
    // Entry and wake counts are short; a 16-bit counter saves area
    localparam [15:0] SLEEP_CYC = SLEEP_CYC_W[15:0];
    localparam [15:0] WAKE_CYC = WAKE_CYC_W[15:0];
    localparam [15:0] WAKE_ID_CYC = WAKE_ID_CYC_W[15:0];

    // Two-flop synchronisers; the first stage feeds only the second
    reg cs_m_ff, cs_s_ff, cs_d_ff;
    reg sck_m_ff, sck_s_ff, sck_d_ff;
    reg di_m_ff, di_s_ff;

    reg [2:0] bit_cnt_ff;
    reg [9:0] byte_cnt_ff;
    reg [6:0] shift_in_ff;
    reg [7:0] cmd_ff;
    reg [23:0] addr_ff;
    reg [7:0] wr_off_ff;
    reg ign_ff;
    reg [7:0] out_sr_ff;
    reg so_ff;
    reg so_oe_ff;

    reg latch_ff;
    reg busy_ff;
    reg sleep_ff;
    reg [31:0] timer_ff;
    reg [15:0] aux_cnt_ff;
    reg aux_run_ff;
    reg aux_kind_ff;

    reg [7:0] page_mem [0:255];
    reg [255:0] loaded_ff;
    reg [15:0] prog_base_ff;
    reg walk_ff;
    reg [7:0] walk_idx_ff;
    reg erase_pend_ff;
    reg [1:0] op_ff;
    reg [23:0] erase_addr_ff;

    wire sel;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;
    wire cs_fall;
    wire byte_done;
    wire [7:0] in_byte;
    wire [7:0] status_byte;
    wire rd_stat;
    wire rd_id;
    wire boundary;
    wire page_prot;
    wire small_prot;
    wire large_prot;
    wire fifo_in_ready;
    wire fifo_in_valid;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire walk_step;
    wire cycle_done;

    // Overlap of [lo,hi] with the externally decoded protected range
    function prot_hit;
        input [23:0] lo;
        input [23:0] hi;
        begin
            prot_hit = prot_valid_in & !(hi < prot_lo_in) &
                !(lo > prot_hi_in);
        end
    endfunction

    assign sel = !cs_s_ff;
    assign sck_rise = sel & sck_s_ff & !sck_d_ff;
    assign sck_fall = sel & !sck_s_ff & sck_d_ff;
    assign cs_rise = cs_s_ff & !cs_d_ff;
    assign cs_fall = !cs_s_ff & cs_d_ff;
    assign byte_done = sck_rise & (bit_cnt_ff == 3'h7);
    assign in_byte = {shift_in_ff, di_s_ff};
    assign boundary = (bit_cnt_ff == 3'h0);
    assign status_byte = {2'h0, protect_sel_3_in, protect_sel_2_in,
        protect_sel_1_in, protect_sel_0_in, latch_ff, busy_ff};
    assign rd_stat = !ign_ff & (cmd_ff == `OP_STATUS_READ) &
        (byte_cnt_ff >= `SINGLE_BYTE);
    assign rd_id = !ign_ff & (cmd_ff == `OP_WAKE) &
        (byte_cnt_ff >= `ID_FIRST_BYTE);
    assign page_prot = prot_hit(addr_ff & ~`PAGE_MASK,
        addr_ff | `PAGE_MASK);
    assign small_prot = prot_hit(addr_ff & ~`SMALL_MASK,
        addr_ff | `SMALL_MASK);
    assign large_prot = prot_hit(addr_ff & ~`LARGE_MASK,
        addr_ff | `LARGE_MASK);

    // Sampling the pins
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_m_ff <= 1'b1;
            cs_s_ff <= 1'b1;
            cs_d_ff <= 1'b1;
            sck_m_ff <= 1'b0;
            sck_s_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            di_m_ff <= 1'b0;
            di_s_ff <= 1'b0;
        end else begin
            cs_m_ff <= cs_n_in;
            cs_s_ff <= cs_m_ff;
            cs_d_ff <= cs_s_ff;
            sck_m_ff <= sclk_in;
            sck_s_ff <= sck_m_ff;
            sck_d_ff <= sck_s_ff;
            di_m_ff <= serial_in_io_in;
            di_s_ff <= di_m_ff;
        end
    end

    // Frame capture: command, address, data
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 10'h000;
            shift_in_ff <= 7'h00;
            cmd_ff <= 8'h00;
            addr_ff <= 24'h000000;
            wr_off_ff <= 8'h00;
            ign_ff <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 10'h000;
            ign_ff <= 1'b0;
        end else if (sck_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_in_ff <= in_byte[6:0];
            if (byte_done) begin
                if (byte_cnt_ff != 10'h3FF) begin
                    byte_cnt_ff <= byte_cnt_ff + 10'h001;
                end
                if (byte_cnt_ff == 10'h000) begin
                    cmd_ff <= in_byte;
                    // Wake pending also blocks: link state is settling
                    if (aux_run_ff) begin
                        ign_ff <= 1'b1;
                    end else if (sleep_ff) begin
                        ign_ff <= (in_byte != `OP_WAKE);
                    end else if (busy_ff) begin
                        ign_ff <= (in_byte != `OP_STATUS_READ);
                    end
                end else if (byte_cnt_ff < `ADDR_LAST_BYTE) begin
                    addr_ff <= {addr_ff[15:0], in_byte};
                    wr_off_ff <= in_byte;
                end else if (!ign_ff && cmd_ff == `OP_PAGE_WRITE) begin
                    wr_off_ff <= wr_off_ff + 8'h01;
                end
            end
        end
    end

    // Page buffer loading; wrap overwrites earlier bytes
    always @(posedge clk_in) begin
        if (byte_done && !ign_ff && cmd_ff == `OP_PAGE_WRITE &&
            byte_cnt_ff >= `ADDR_LAST_BYTE) begin
            page_mem[wr_off_ff] <= in_byte;
        end
    end

    // Readout on falling edges, reloaded every byte
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_sr_ff <= 8'h00;
            so_ff <= `RST_SO;
            so_oe_ff <= 1'b0;
        end else if (!sel) begin
            so_oe_ff <= 1'b0;
        end else if (sck_fall) begin
            so_oe_ff <= rd_stat | rd_id;
            if (boundary) begin
                so_ff <= rd_id ? DEVICE_ID[7] : status_byte[7];
                out_sr_ff <= rd_id ? {DEVICE_ID[6:0], 1'b0} :
                    {status_byte[6:0], 1'b0};
            end else begin
                so_ff <= out_sr_ff[7];
                out_sr_ff <= {out_sr_ff[6:0], 1'b0};
            end
        end
    end

    // Walker moves loaded bytes into the FIFO; stalls when it fills
    assign fifo_in_valid = walk_ff & loaded_ff[walk_idx_ff];
    assign walk_step = walk_ff & (!loaded_ff[walk_idx_ff] | fifo_in_ready);
    assign cycle_done = busy_ff & (timer_ff == 32'h0) & !walk_ff &
        !fifo_out_valid & !erase_pend_ff;

    page_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in({walk_idx_ff, page_mem[walk_idx_ff]}),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(mem_ready_in & !erase_pend_ff),
        .out_data_out(fifo_out_data)
    );

    // Command execution at select release
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latch_ff <= `RST_LATCH;
            busy_ff <= 1'b0;
            sleep_ff <= `RST_SLEEP;
            timer_ff <= 32'h0;
            aux_cnt_ff <= 16'h0000;
            aux_run_ff <= 1'b0;
            aux_kind_ff <= 1'b0;
            loaded_ff <= {256{1'b0}};
            prog_base_ff <= 16'h0000;
            walk_ff <= 1'b0;
            walk_idx_ff <= 8'h00;
            erase_pend_ff <= 1'b0;
            op_ff <= `MEMOP_PROG;
            erase_addr_ff <= 24'h000000;
        end else begin
            if (timer_ff != 32'h0) begin
                timer_ff <= timer_ff - 32'h1;
            end
            if (walk_step) begin
                walk_idx_ff <= walk_idx_ff + 8'h01;
                if (walk_idx_ff == 8'hFF) begin
                    walk_ff <= 1'b0;
                end
            end
            if (erase_pend_ff & mem_ready_in) begin
                erase_pend_ff <= 1'b0;
            end
            if (cycle_done) begin
                busy_ff <= 1'b0;
                latch_ff <= 1'b0;
            end
            if (aux_run_ff) begin
                if (aux_cnt_ff == 16'h0000) begin
                    aux_run_ff <= 1'b0;
                    sleep_ff <= aux_kind_ff;
                end else begin
                    aux_cnt_ff <= aux_cnt_ff - 16'h0001;
                end
            end
            if (byte_done && byte_cnt_ff == 10'h000 &&
                in_byte == `OP_PAGE_WRITE && !busy_ff && !sleep_ff) begin
                loaded_ff <= {256{1'b0}};
            end else if (byte_done && !ign_ff &&
                cmd_ff == `OP_PAGE_WRITE &&
                byte_cnt_ff >= `ADDR_LAST_BYTE) begin
                loaded_ff[wr_off_ff] <= 1'b1;
            end
            // Off-boundary release discards everything
            if (cs_rise && !ign_ff && boundary &&
                byte_cnt_ff != 10'h000) begin
                case (cmd_ff)
                    `OP_WRITE_ENABLE: begin
                        latch_ff <= 1'b1;
                    end
                    `OP_WRITE_DISABLE: begin
                        latch_ff <= 1'b0;
                    end
                    `OP_PAGE_WRITE: begin
                        if (byte_cnt_ff > `ADDR_LAST_BYTE && latch_ff &&
                            !page_prot) begin
                            busy_ff <= 1'b1;
                            timer_ff <= PAGE_WRITE_CYC - 32'h1;
                            prog_base_ff <= addr_ff[23:8];
                            walk_ff <= 1'b1;
                            walk_idx_ff <= 8'h00;
                            op_ff <= `MEMOP_PROG;
                        end
                    end
                    `OP_SMALL_ERASE: begin
                        if (byte_cnt_ff == `ADDR_LAST_BYTE && latch_ff &&
                            !small_prot) begin
                            busy_ff <= 1'b1;
                            timer_ff <= SMALL_ERASE_CYC - 32'h1;
                            erase_pend_ff <= 1'b1;
                            op_ff <= `MEMOP_SMALL;
                            erase_addr_ff <= addr_ff & ~`SMALL_MASK;
                        end
                    end
                    `OP_LARGE_ERASE: begin
                        if (byte_cnt_ff == `ADDR_LAST_BYTE && latch_ff &&
                            !large_prot) begin
                            busy_ff <= 1'b1;
                            timer_ff <= LARGE_ERASE_CYC - 32'h1;
                            erase_pend_ff <= 1'b1;
                            op_ff <= `MEMOP_LARGE;
                            erase_addr_ff <= addr_ff & ~`LARGE_MASK;
                        end
                    end
                    `OP_FULL_ERASE: begin
                        if (byte_cnt_ff == `SINGLE_BYTE && latch_ff &&
                            !prot_valid_in) begin
                            busy_ff <= 1'b1;
                            timer_ff <= FULL_ERASE_CYC - 32'h1;
                            erase_pend_ff <= 1'b1;
                            op_ff <= `MEMOP_FULL;
                            erase_addr_ff <= 24'h000000;
                        end
                    end
                    `OP_SLEEP: begin
                        if (byte_cnt_ff == `SINGLE_BYTE) begin
                            aux_run_ff <= 1'b1;
                            aux_kind_ff <= 1'b1;
                            aux_cnt_ff <= SLEEP_CYC - 16'h0001;
                        end
                    end
                    `OP_WAKE: begin
                        // Busy case already flagged ignored at command
                        if (sleep_ff) begin
                            aux_run_ff <= 1'b1;
                            aux_kind_ff <= 1'b0;
                            aux_cnt_ff <= (byte_cnt_ff == `SINGLE_BYTE) ?
                                WAKE_CYC - 16'h0001 :
                                WAKE_ID_CYC - 16'h0001;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Program data only clears bits; array ANDs it in
    assign mem_valid_out = erase_pend_ff | fifo_out_valid;
    assign mem_op_out = op_ff;
    assign mem_addr_out = erase_pend_ff ? erase_addr_ff :
        {prog_base_ff, fifo_out_data[15:8]};
    assign mem_data_out = erase_pend_ff ? 8'hFF : fifo_out_data[7:0];

    assign so_out = so_ff;
    assign so_oe_out = so_oe_ff;
    // Dual output unused: line stays an input
    assign serial_in_io_out = 1'b0;
    assign serial_in_io_oe_out = 1'b0;
    assign busy_out = busy_ff;
    assign write_latch_flag_out = latch_ff;
    assign sleep_out = sleep_ff;
endmodule // flash_seq

// ===== dv/flash_seq_monitor.sv
`timescale 1ns/1ps
module flash_seq_monitor (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Link and protection
    input wire cs_n_in,
    input wire serial_in_io_oe_out,
    input wire serial_in_io_out,
    input wire so_oe_out,
    input wire prot_valid_in,
    // Array port
    input wire mem_valid_out,
    input wire mem_ready_in,
    input wire [1:0] mem_op_out,
    input wire [23:0] mem_addr_out,
    input wire [7:0] mem_data_out,
    // Status
    input wire busy_out,
    input wire write_latch_flag_out,
    input wire sleep_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence op_start;
        $rose(busy_out);
    endsequence
    sequence op_end;
        $fell(busy_out);
    endsequence
    sequence mem_stall;
        mem_valid_out && !mem_ready_in;
    endsequence
    busy_latch_a: assert property (op_start |-> write_latch_flag_out)
        else $error("op started without latch");
    latch_clear_a: assert property (op_end |-> !write_latch_flag_out)
        else $error("latch kept after op");
    port_drain_a: assert property (op_end |-> !mem_valid_out)
        else $error("busy fell with array request open");
    busy_hold_a: assert property (op_start |-> busy_out[*8])
        else $error("op cycle too short");
    start_cs_a: assert property (op_start |-> $past(cs_n_in, 2))
        else $error("op started with select low");
    mem_hold_a: assert property (mem_stall |=> mem_valid_out
        && $stable(mem_addr_out) && $stable(mem_data_out))
        else $error("array request changed before taken");
    mem_busy_a: assert property (mem_valid_out |-> busy_out)
        else $error("array request outside busy");
    erase_fill_a: assert property (mem_valid_out && mem_op_out != 2'h0
        |-> mem_data_out == 8'hFF)
        else $error("erase data not all ones");
    sector_base_a: assert property (mem_valid_out && mem_op_out == 2'h1
        |-> mem_addr_out[11:0] == 12'h000)
        else $error("sector base misaligned");
    block_base_a: assert property (mem_valid_out && mem_op_out == 2'h2
        |-> mem_addr_out[15:0] == 16'h0000)
        else $error("block base misaligned");
    chip_erase_a: assert property (mem_valid_out && mem_op_out == 2'h3
        |-> mem_addr_out == 24'h000000 && !prot_valid_in)
        else $error("chip erase wrong or protected");
    sleep_idle_a: assert property (sleep_out |-> !busy_out)
        else $error("busy while asleep");
    input_only_a: assert property (!serial_in_io_oe_out
        && !serial_in_io_out)
        else $error("input line driven");
    // Synchroniser lag: enable may stand three cycles past select
    oe_release_a: assert property (cs_n_in[*4] |-> !so_oe_out)
        else $error("output enabled with select high");
endmodule // flash_seq_monitor

bind flash_seq flash_seq_monitor flash_seq_monitor_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
    .serial_in_io_oe_out(serial_in_io_oe_out),
    .serial_in_io_out(serial_in_io_out), .so_oe_out(so_oe_out),
    .prot_valid_in(prot_valid_in), .mem_valid_out(mem_valid_out),
    .mem_ready_in(mem_ready_in), .mem_op_out(mem_op_out),
    .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
    .busy_out(busy_out), .write_latch_flag_out(write_latch_flag_out),
    .sleep_out(sleep_out));

// ===== dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input wire clk_in,
    // Serial link
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out,
    input wire so_in
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end
    // Clock idles low and stands still between frames
    task automatic run(input int nbits);
        logic [7:0] sh;
        logic [7:0] rx;
        rxq.delete();
        @(posedge clk_in) cs_n_out <= 1'b0;
        // Data moves with the falling edge: 4 low, 4 high, 80 ns period
        for (int i = 0; i < nbits; i++) begin
            sh = txq[i / 8];
            @(posedge clk_in) sclk_out <= 1'b0;
            mosi_out <= sh[7 - i % 8];
            repeat (3) @(posedge clk_in);
            @(posedge clk_in) sclk_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            #1;
            rx = {rx[6:0], so_in};
            if (i % 8 == 7) rxq.push_back(rx);
        end
        @(posedge clk_in) sclk_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(posedge clk_in) cs_n_out <= 1'b1;
        // Released line must not look like held data
        mosi_out <= ~mosi_out;
        txq.delete();
        repeat (6) @(posedge clk_in);
    endtask
endmodule // spi_host_model

// ===== dv/flash_seq_tb.sv
`timescale 1ns/1ps
module flash_seq_tb;
    localparam [7:0] ID = 8'h3C; // Arbitrary value
    logic clk_in, rst_n_in, mem_ready, prot_valid;
    logic [3:0] psel;
    logic [23:0] prot_lo, prot_hi;
    logic [7:0] d0, d1, d2;
    wire cs_n, sclk, mosi, so, mem_valid, busy, latch, sleep;
    wire [1:0] mem_op;
    wire [23:0] mem_addr;
    wire [7:0] mem_data;
    int num_errors = 0;
    int checked = 0;
    int seed = 81;
    logic [33:0] expq[$];
    logic [7:0] opc[3] = '{8'h20, 8'hD8, 8'hC7};
    logic [23:0] msk[3] = '{24'h000FFF, 24'h00FFFF, 24'hFFFFFF};

    flash_seq #(.PAGE_WRITE_CYC(2000), .SMALL_ERASE_CYC(600),
        .LARGE_ERASE_CYC(700), .FULL_ERASE_CYC(800), .DEVICE_ID(ID))
    flash_seq_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n),
        .sclk_in(sclk), .serial_in_io_in(mosi), .serial_in_io_out(),
        .serial_in_io_oe_out(), .so_out(so), .so_oe_out(),
        .protect_sel_3_in(psel[3]), .protect_sel_2_in(psel[2]),
        .protect_sel_1_in(psel[1]), .protect_sel_0_in(psel[0]),
        .prot_valid_in(prot_valid), .prot_lo_in(prot_lo),
        .prot_hi_in(prot_hi), .mem_valid_out(mem_valid),
        .mem_ready_in(mem_ready), .mem_op_out(mem_op),
        .mem_addr_out(mem_addr), .mem_data_out(mem_data),
        .busy_out(busy), .write_latch_flag_out(latch), .sleep_out(sleep));
    spi_host_model spi_host_model_i (.clk_in(clk_in), .cs_n_out(cs_n),
        .sclk_out(sclk), .mosi_out(mosi), .so_in(so));

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tx(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
            spi_host_model_i.txq.push_back(w[8*i +: 8]);
    endtask
    task automatic go(input int cut);
        spi_host_model_i.run(8 * spi_host_model_i.txq.size() - cut);
    endtask
    task automatic status(input logic l, input logic b);
        tx(32'h0500, 2);
        go(0);
        chk(spi_host_model_i.rxq[1], {2'b00, psel, l, b});
    endtask
    task automatic await(input logic on_sleep, input logic v);
        int n;
        n = 0;
        while ((on_sleep ? sleep : busy) !== v && n < 5000) begin
            @(posedge clk_in);
            n++;
        end
        chk(n < 5000, 1);
    endtask

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Array side stalls at random
    always @(posedge clk_in) mem_ready <= $random(seed);
    always @(posedge clk_in) begin
        if (rst_n_in && mem_valid && mem_ready) begin
            if (expq.size() == 0) chk(1, 0);
            else chk({mem_op, mem_addr, mem_data}, expq.pop_front());
        end
    end
    initial begin
        #600000;
        num_errors++;
        end_of_test;
    end
    initial begin
        rst_n_in = 1'b0;
        prot_valid = 1'b0;
        prot_lo = 24'h010000;
        prot_hi = 24'h01FFFF;
        psel = $random(seed);
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk(sleep, 0);
        status(0, 0);
        tx(32'h020012FE, 4);
        tx(32'hA5, 1);
        go(0);
        chk(busy, 0);
        tx(32'h06, 1);
        go(0);
        chk(latch, 1);
        d0 = $random(seed);
        d1 = $random(seed);
        d2 = $random(seed);
        tx(32'h020012FE, 4);
        tx({d0, d1, d2}, 3);
        expq.push_back({2'h0, 24'h001200, d2});
        expq.push_back({2'h0, 24'h0012FE, d0});
        expq.push_back({2'h0, 24'h0012FF, d1});
        go(0);
        status(1, 1);
        tx(32'hAB, 1);
        go(0);
        chk(sleep, 0);
        await(0, 0);
        chk(latch, 0);
        for (int k = 0; k < 3; k++) begin
            tx(32'h06, 1);
            go(0);
            d0 = $random(seed);
            if (k < 2) tx({opc[k], 16'h05AB, d0}, 4);
            else tx(opc[k], 1);
            expq.push_back({2'(k + 1), 24'h05AB00 & ~msk[k], 8'hFF});
            go(0);
            chk(busy, 1);
            await(0, 0);
            chk(latch, 0);
        end
        prot_valid <= 1'b1;
        tx(32'h06, 1);
        go(0);
        tx(32'h20011000, 4);
        go(0);
        chk(busy, 0);
        tx(32'hC7, 1);
        go(0);
        chk(busy, 0);
        prot_valid <= 1'b0;
        tx(32'h20023000, 4);
        go(1);
        chk(busy, 0);
        tx(32'h04, 1);
        go(0);
        chk(latch, 0);
        tx(32'hB9, 1);
        go(0);
        await(1, 1);
        tx(32'h06, 1);
        go(0);
        chk(latch, 0);
        tx(32'hAB, 1);
        go(0);
        await(1, 0);
        repeat (10) @(posedge clk_in);
        status(0, 0);
        tx(32'hB9, 1);
        go(0);
        await(1, 1);
        tx(32'hAB000000, 4);
        tx(32'h00, 2);
        go(0);
        chk(spi_host_model_i.rxq[4], ID);
        chk(spi_host_model_i.rxq[5], ID);
        await(1, 0);
        repeat (10) @(posedge clk_in);
        status(0, 0);
        chk(expq.size(), 0);
        end_of_test;
    end
endmodule // flash_seq_tb
